/* hdl/ppsr_defines.vh */
/*
 Constants for the port status register page block: register addresses,
 field positions, reset values and selector codes.
 Assumes the includer uses a 4-bit register address and 8-bit data.
*/
`ifndef PPSR_DEFINES_VH
`define PPSR_DEFINES_VH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define PPSR_ADDR_BASE_CTRL   4'h7
`define PPSR_ADDR_LINE_STATE  4'h8
`define PPSR_ADDR_SPEED_EVT   4'h9
`define PPSR_ADDR_VDEP_FIRST  4'h8
`define PPSR_PAGE_MSB         3

// ----------------------------------------------------------------------------
// Base control register fields
// ----------------------------------------------------------------------------
`define PPSR_B_TIMEOUT        0
`define PPSR_B_PORT_EVENT     1
`define PPSR_B_ACCEL          2
`define PPSR_B_MULTI          3
`define PPSR_B_WATCHDOG       4

// ----------------------------------------------------------------------------
// Selector fields, register at address 0x6 of the base page
// ----------------------------------------------------------------------------
`define PPSR_ADDR_SELECT      4'h6
`define PPSR_F_PORT_LO        0
`define PPSR_F_PORT_HI        3
`define PPSR_F_PAGE_LO        5
`define PPSR_F_PAGE_HI        7

// ----------------------------------------------------------------------------
// Page and port codes
// ----------------------------------------------------------------------------
`define PPSR_PAGE_STATUS      3'h0
`define PPSR_PAGE_VID         3'h1
`define PPSR_PAGE_VDEP        3'h7
`define PPSR_PORT_0           4'h0
`define PPSR_PORT_1           4'h1
`define PPSR_PORT_2           4'h2
`define PPSR_NPORTS           3

// ----------------------------------------------------------------------------
// Port status fields
// ----------------------------------------------------------------------------
`define PPSR_P_CONNECT        5
`define PPSR_P_BIAS           6
`define PPSR_P_OFF            7
`define PPSR_P_INTEN          3
`define PPSR_P_FAULT          4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PPSR_RST_BIT          1'h0
`define PPSR_RST_PAGE         3'h0
`define PPSR_RST_PORT         4'h0
`define PPSR_RST_BYTE         8'h00
`define PPSR_ZERO8            8'h00

// ----------------------------------------------------------------------------
// Vendor identification, arbitrary neutral values
// ----------------------------------------------------------------------------
`define PPSR_COMPLIANCE       8'h01
`define PPSR_VENDOR_ID        24'h123456
`define PPSR_PRODUCT_ID       24'hABCDEF

`endif

/* hdl/ppsr_port_slot.v */
/*
 Per-port status slot: samples the port's connect and bias inputs, holds its
 writable bits and reports a change event for the port activity flag.
 Assumes the status inputs are synchronous to CLK.
*/
`timescale 1ns/1ps
`include "ppsr_defines.vh"

module ppsr_port_slot
(
	input  wire       CLK,
	input  wire       RST,
	input  wire [1:0] line_a_state,
	input  wire [1:0] line_b_state,
	input  wire       child_in,
	input  wire       connect_in,
	input  wire       bias_in,
	input  wire [2:0] speed_in,
	input  wire       susp_err_in,
	input  wire       resume_done_in,
	input  wire       wr_line,
	input  wire       wr_speed,
	input  wire [7:0] wdata,
	output wire [7:0] line_byte,
	output wire [7:0] speed_byte,
	output wire       port_off,
	output wire       change_evt,
	output wire       resume_evt
);

	reg        off_reg;
	reg        inten_reg;
	reg        conn_reg;
	reg        bias_reg;
	wire       fault_reg;
	wire       off_next;

	assign off_next = wr_line ? wdata[`PPSR_P_OFF] : off_reg;

	// ------------------------------------------------------------------------
	// Writable bits and sampled status
	// ------------------------------------------------------------------------
	always @(posedge CLK)
	begin
		if (RST)
		begin
			off_reg   <= `PPSR_RST_BIT;
			inten_reg <= `PPSR_RST_BIT;
			conn_reg  <= `PPSR_RST_BIT;
			bias_reg  <= `PPSR_RST_BIT;
		end
		else
		begin
			off_reg  <= off_next;
			conn_reg <= connect_in;
			bias_reg <= bias_in;
			if (wr_speed)
				inten_reg <= wdata[`PPSR_P_INTEN];
		end
	end

	ppsr_w1c_flag u_fault
	(
		.CLK      (CLK),
		.RST      (RST),
		.set_in   (susp_err_in),
		.clr_in   (wr_speed & wdata[`PPSR_P_FAULT]),
		.flag_reg (fault_reg)
	);

	assign port_off   = off_reg;
	assign resume_evt = resume_done_in;
	// Any change of connect, bias, off or fault while enabled.
	assign change_evt = inten_reg & ((connect_in != conn_reg) | (bias_in != bias_reg)
		| (off_next != off_reg) | (susp_err_in & ~fault_reg)
		| (wr_speed & wdata[`PPSR_P_FAULT] & fault_reg & ~susp_err_in));

	assign line_byte  = {off_reg, bias_reg, conn_reg, child_in,
		line_b_state, line_a_state};
	assign speed_byte = {3'h0, fault_reg, inten_reg, speed_in};

endmodule // ppsr_port_slot

/* hdl/ppsr_top.v */
/*
 Port status register page with the last base control bits: arbitration
 time-out, port event, acceleration, multi-speed, page and port select.
 Assumes a link-side master with one-cycle strobes, read data a cycle later.
*/
// Operation
// - Arbitration time-out sets expiry flag; reset 0, write 1 clears.
// - Enabled port change of attach, bias, off, fault sets event flag.
// - Resume completion with resume alert enable sets event flag.
// - Acceleration bit enables ack acceleration and fly-by; resets 0.
// - Multi-speed bit: each packet own speed, else first packet speed.
// - Page selector, reset 000, picks page at addresses 8 to 15.
// - Port selector, reset 0000, picks shown port 0, 1 or 2.
// - Reserved bits and addresses of the status page read zero.
// - Line A and B states are 2-bit read-only fields per port; both read the port's one LINE_STATE pair.
// - Downstream bit reads 1 for child, 0 for parent connection.
// - Attachment bit reads connection state and resets to 0.
// - Bias bit reads 1 when bias voltage is present.
// - Per-port off bit is writable and resets to 0.
// - 3-bit negotiated speed field gives peer maximum rate.
// - Per-port change enable, reset 0, gates the port's change events, not resume events.
// - Per-port suspend error bit set on error; write 1 clears.
// - Link-on not raised for loop, fail, time-out if both low.
`timescale 1ns/1ps
`include "ppsr_defines.vh"

module ppsr_top
(
	input  wire       CLK,
	input  wire       RST,
	input  wire [3:0] ADDR,
	input  wire [7:0] WDATA,
	input  wire       WR,
	input  wire       RD,
	output reg  [7:0] RDATA,
	input  wire       ARB_TIMEOUT,
	input  wire       LOOP_EVT,
	input  wire       PWR_FAIL_EVT,
	input  wire       LINK_POWER_STATUS,
	input  wire       REQ_PENDING,
	input  wire [5:0] LINE_STATE,
	input  wire [2:0] CHILD,
	input  wire [2:0] CONNECT,
	input  wire [2:0] BIAS,
	input  wire [8:0] SPEED,
	input  wire [2:0] SUSP_ERR,
	input  wire [2:0] RESUME_DONE,
	output reg  [2:0] PORT_OFF,
	output reg        ACCEL_EN,
	output reg        MULTI_SPEED_EN,
	output reg        LINK_ON_INDICATION
);

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	reg        accel_reg;
	reg        multi_reg;
	reg        watchdog_reg;
	reg  [2:0] page_reg;
	reg  [3:0] port_reg;
	reg  [7:0] vdep_mem [0:7];
	reg  [7:0] rdata_next;
	wire       timeout_reg;
	wire       event_reg;
	wire [7:0] line_bytes  [0:2];
	wire [7:0] speed_bytes [0:2];
	wire [2:0] change_evt;
	wire [2:0] resume_evt;
	wire [2:0] off_w;
	wire       wr_base;
	wire       wr_sel;
	wire       upper;
	wire       port_ok;
	wire [1:0] port_idx;
	wire [23:0] vendor_id;
	wire [23:0] product_id;
	integer    i;

	// Decodes a write strobe for one address of the port status page.
	function page_hit;
		input [3:0] addr;
		input [3:0] want;
		input [2:0] page;
		begin
			page_hit = (addr == want) && (page == `PPSR_PAGE_STATUS);
		end
	endfunction

	assign wr_base  = WR && (ADDR == `PPSR_ADDR_BASE_CTRL);
	assign wr_sel   = WR && (ADDR == `PPSR_ADDR_SELECT);
	assign upper    = ADDR[`PPSR_PAGE_MSB];
	assign port_ok  = (port_reg == `PPSR_PORT_0) || (port_reg == `PPSR_PORT_1)
		|| (port_reg == `PPSR_PORT_2);
	assign port_idx = port_reg[1:0];
	assign vendor_id  = `PPSR_VENDOR_ID;
	assign product_id = `PPSR_PRODUCT_ID;

	// ------------------------------------------------------------------------
	// Per-port slots
	// ------------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `PPSR_NPORTS; g = g + 1)
		begin : gen_port
			ppsr_port_slot u_slot
			(
				.CLK            (CLK),
				.RST            (RST),
				.line_a_state   (LINE_STATE[2*g+1:2*g]),
				.line_b_state   (LINE_STATE[2*g+1:2*g]),
				.child_in       (CHILD[g]),
				.connect_in     (CONNECT[g]),
				.bias_in        (BIAS[g]),
				.speed_in       (SPEED[3*g+2:3*g]),
				.susp_err_in    (SUSP_ERR[g]),
				.resume_done_in (RESUME_DONE[g]),
				.wr_line        (WR && page_hit(ADDR, `PPSR_ADDR_LINE_STATE, page_reg)
					&& port_ok && (port_idx == g)),
				.wr_speed       (WR && page_hit(ADDR, `PPSR_ADDR_SPEED_EVT, page_reg)
					&& port_ok && (port_idx == g)),
				.wdata          (WDATA),
				.line_byte      (line_bytes[g]),
				.speed_byte     (speed_bytes[g]),
				.port_off       (off_w[g]),
				.change_evt     (change_evt[g]),
				.resume_evt     (resume_evt[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Sticky flags
	// ------------------------------------------------------------------------
	ppsr_w1c_flag u_timeout
	(
		.CLK      (CLK),
		.RST      (RST),
		.set_in   (ARB_TIMEOUT),
		.clr_in   (wr_base & WDATA[`PPSR_B_TIMEOUT]),
		.flag_reg (timeout_reg)
	);

	ppsr_w1c_flag u_event
	(
		.CLK      (CLK),
		.RST      (RST),
		.set_in   ((|change_evt) | (watchdog_reg & (|resume_evt))),
		.clr_in   (wr_base & WDATA[`PPSR_B_PORT_EVENT]),
		.flag_reg (event_reg)
	);

	// ------------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------------
	always @(posedge CLK)
	begin
		if (RST)
		begin
			accel_reg    <= `PPSR_RST_BIT;
			multi_reg    <= `PPSR_RST_BIT;
			watchdog_reg <= `PPSR_RST_BIT;
			page_reg     <= `PPSR_RST_PAGE;
			port_reg     <= `PPSR_RST_PORT;
			for (i = 0; i < 8; i = i + 1)
				vdep_mem[i] <= `PPSR_RST_BYTE;
		end
		else
		begin
			if (wr_base)
			begin
				// The link must hold this steady while a request is pending.
				accel_reg    <= WDATA[`PPSR_B_ACCEL];
				multi_reg    <= WDATA[`PPSR_B_MULTI];
				watchdog_reg <= WDATA[`PPSR_B_WATCHDOG];
			end
			if (wr_sel)
			begin
				page_reg <= WDATA[`PPSR_F_PAGE_HI:`PPSR_F_PAGE_LO];
				port_reg <= WDATA[`PPSR_F_PORT_HI:`PPSR_F_PORT_LO];
			end
			// Vendor-dependent array answers only with port 1 selected.
			if (WR && upper && (page_reg == `PPSR_PAGE_VDEP) && (port_reg == `PPSR_PORT_1))
				vdep_mem[ADDR[2:0]] <= WDATA;
		end
	end

	// ------------------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------------------
	always @*
	begin
		rdata_next = `PPSR_ZERO8;
		if (ADDR == `PPSR_ADDR_BASE_CTRL)
			rdata_next = {3'h0, watchdog_reg, multi_reg, accel_reg, event_reg, timeout_reg};
		else if (ADDR == `PPSR_ADDR_SELECT)
			rdata_next = {page_reg, 1'b0, port_reg};
		else if (upper)
		begin
			case (page_reg)
				`PPSR_PAGE_STATUS:
				begin
					if (port_ok && (ADDR == `PPSR_ADDR_LINE_STATE))
						rdata_next = line_bytes[port_idx];
					else if (port_ok && (ADDR == `PPSR_ADDR_SPEED_EVT))
						rdata_next = speed_bytes[port_idx];
				end
				`PPSR_PAGE_VID:
				begin
					case (ADDR[2:0])
						3'h0: rdata_next = `PPSR_COMPLIANCE;
						3'h2: rdata_next = vendor_id[23:16];
						3'h3: rdata_next = vendor_id[15:8];
						3'h4: rdata_next = vendor_id[7:0];
						3'h5: rdata_next = product_id[23:16];
						3'h6: rdata_next = product_id[15:8];
						3'h7: rdata_next = product_id[7:0];
						default: rdata_next = `PPSR_ZERO8;
					endcase
				end
				`PPSR_PAGE_VDEP:
				begin
					if (port_reg == `PPSR_PORT_1)
						rdata_next = vdep_mem[ADDR[2:0]];
				end
				default: rdata_next = `PPSR_ZERO8;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------------------
	always @(posedge CLK)
	begin
		if (RST)
		begin
			RDATA              <= `PPSR_ZERO8;
			PORT_OFF           <= 3'h0;
			ACCEL_EN           <= `PPSR_RST_BIT;
			MULTI_SPEED_EN     <= `PPSR_RST_BIT;
			LINK_ON_INDICATION <= `PPSR_RST_BIT;
		end
		else
		begin
			RDATA          <= RD ? rdata_next : `PPSR_ZERO8;
			PORT_OFF       <= off_w;
			ACCEL_EN       <= accel_reg;
			MULTI_SPEED_EN <= multi_reg;
			// Suppressed while link power and resume alert are both low.
			LINK_ON_INDICATION <= (LINK_POWER_STATUS | watchdog_reg)
				& (LOOP_EVT | PWR_FAIL_EVT | timeout_reg);
		end
	end

endmodule // ppsr_top

/* hdl/ppsr_w1c_flag.v */
/*
 One write-one-to-clear flag that hardware sets.
 Assumes set and clear are one-cycle conditions in the CLK domain.
*/
`timescale 1ns/1ps
`include "ppsr_defines.vh"

module ppsr_w1c_flag
(
	input  wire CLK,
	input  wire RST,
	input  wire set_in,
	input  wire clr_in,
	output reg  flag_reg
);

	// ------------------------------------------------------------------------
	// Flag with set priority
	// ------------------------------------------------------------------------
	always @(posedge CLK)
	begin
		if (RST)
			flag_reg <= `PPSR_RST_BIT;
		else if (set_in)
			flag_reg <= 1'b1;
		else if (clr_in)
			flag_reg <= 1'b0;
	end

endmodule // ppsr_w1c_flag

/* testbench/phy_port_status_register_page_tb.sv */
/*
 Self-checking testbench for the port status register page.
 Assumes the link model drives the bus and the bench drives port status.
*/
`timescale 1ns/1ps

module phy_port_status_register_page_tb;
	reg        CLK = 1'b0;
	reg        RST = 1'b1;
	reg        ARB_TIMEOUT = 1'b0, LOOP_EVT = 1'b0, PWR_FAIL_EVT = 1'b0, LINK_POWER_STATUS = 1'b0;
	reg  [5:0] LINE_STATE = 6'h39;
	reg  [2:0] CHILD = 3'h5, CONNECT = 3'h3, BIAS = 3'h6, SUSP_ERR = 3'h0, RESUME_DONE = 3'h0;
	reg  [8:0] SPEED = 9'h088;
	wire [3:0] ADDR;
	wire [7:0] WDATA, RDATA;
	wire       WR, RD, REQ_PENDING, ACCEL_EN, MULTI_SPEED_EN, LINK_ON_INDICATION;
	wire [2:0] PORT_OFF;
	integer    err_total = 0, n_compared = 0, cyc = 0, g;
	reg  [7:0] v, e;

	always #5 CLK = ~CLK;

	ppsr_top u_ppsr_top (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .ARB_TIMEOUT(ARB_TIMEOUT), .LOOP_EVT(LOOP_EVT), .PWR_FAIL_EVT(PWR_FAIL_EVT),
		.LINK_POWER_STATUS(LINK_POWER_STATUS), .REQ_PENDING(REQ_PENDING), .LINE_STATE(LINE_STATE),
		.CHILD(CHILD), .CONNECT(CONNECT), .BIAS(BIAS), .SPEED(SPEED), .SUSP_ERR(SUSP_ERR),
		.RESUME_DONE(RESUME_DONE), .PORT_OFF(PORT_OFF), .ACCEL_EN(ACCEL_EN),
		.MULTI_SPEED_EN(MULTI_SPEED_EN), .LINK_ON_INDICATION(LINK_ON_INDICATION));
	ppsr_link u_ppsr_link (.CLK(CLK), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.REQ_PENDING(REQ_PENDING), .RDATA(RDATA));

	task chk(input [7:0] got, input [7:0] exp);
	begin
		n_compared = n_compared + 1;
		if (got !== exp)
		begin
			err_total = err_total + 1;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask

	task rchk(input [3:0] a, input [7:0] exp);
	begin
		u_ppsr_link.rd(a, v);
		chk(v, exp);
	end
	endtask

	task w(input [3:0] a, input [7:0] d);
		u_ppsr_link.wr(a, d);
	endtask

	task stop_test;
	begin
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask

	task t_status;
	begin
		rchk(4'h6, 8'h00);
		rchk(4'h7, 8'h00);
		chk({5'h0, PORT_OFF}, 8'h00);
		for (g = 0; g < 3; g = g + 1)
		begin
			u_ppsr_link.sel(3'h0, g[3:0]);
			e = {1'b0, BIAS[g], CONNECT[g], CHILD[g], {2{LINE_STATE[2*g +: 2]}}};
			rchk(4'h8, e);
			rchk(4'h9, {5'h0, SPEED[3*g +: 3]});
			rchk(4'hA + g[3:0], 8'h00);
		end
		u_ppsr_link.sel(3'h0, 4'h3);
		rchk(4'h8, 8'h00);
		$display("status fields done");
	end
	endtask

	task t_event;
	begin
		@(posedge CLK) CONNECT <= CONNECT ^ 3'h1;
		rchk(4'h7, 8'h00);
		u_ppsr_link.sel(3'h0, 4'h1);
		w(4'h9, 8'h08);
		@(posedge CLK) CONNECT <= CONNECT ^ 3'h2;
		rchk(4'h7, 8'h02);
		w(4'h7, 8'h00);
		rchk(4'h7, 8'h02);
		w(4'h7, 8'h02);
		rchk(4'h7, 8'h00);
		@(posedge CLK) SUSP_ERR <= 3'h2;
		@(posedge CLK) SUSP_ERR <= 3'h0;
		w(4'h9, 8'h08);
		rchk(4'h9, 8'h19);
		w(4'h9, 8'h18);
		rchk(4'h9, 8'h09);
		rchk(4'h7, 8'h02);
		w(4'h7, 8'h02);
		w(4'h8, 8'h80);
		@(posedge CLK);
		#1 chk({5'h0, PORT_OFF}, 8'h02);
		rchk(4'h7, 8'h02);
		w(4'h8, 8'h00);
		rchk(4'h7, 8'h02);
		w(4'h7, 8'h02);
		$display("port event done");
	end
	endtask

	task t_flags;
	begin
		w(4'h7, 8'h10);
		@(posedge CLK) RESUME_DONE <= 3'h4;
		@(posedge CLK) RESUME_DONE <= 3'h0;
		rchk(4'h7, 8'h12);
		w(4'h7, 8'h02);
		@(posedge CLK) RESUME_DONE <= 3'h4;
		@(posedge CLK) RESUME_DONE <= 3'h0;
		rchk(4'h7, 8'h00);
		@(posedge CLK) ARB_TIMEOUT <= 1'b1;
		LOOP_EVT <= 1'b1;
		@(posedge CLK) ARB_TIMEOUT <= 1'b0;
		rchk(4'h7, 8'h01);
		chk({7'h0, LINK_ON_INDICATION}, 8'h00);
		w(4'h7, 8'h00);
		rchk(4'h7, 8'h01);
		fork
			w(4'h7, 8'h01);
			begin
				@(posedge CLK) ARB_TIMEOUT <= 1'b1;
				@(posedge CLK) ARB_TIMEOUT <= 1'b0;
			end
		join
		rchk(4'h7, 8'h01);
		w(4'h7, 8'h01);
		rchk(4'h7, 8'h00);
		@(posedge CLK) LINK_POWER_STATUS <= 1'b1;
		LOOP_EVT <= 1'b0;
		@(posedge CLK) ARB_TIMEOUT <= 1'b1;
		@(posedge CLK) ARB_TIMEOUT <= 1'b0;
		repeat (2) @(posedge CLK);
		chk({7'h0, LINK_ON_INDICATION}, 8'h01);
		w(4'h7, 8'h01);
		@(posedge CLK) PWR_FAIL_EVT <= 1'b1;
		@(posedge CLK) PWR_FAIL_EVT <= 1'b0;
		LINK_POWER_STATUS <= 1'b0;
		$display("flags done");
	end
	endtask

	task t_ctrl;
	begin
		w(4'h7, 8'h0C);
		rchk(4'h7, 8'h0C);
		chk({6'h0, MULTI_SPEED_EN, ACCEL_EN}, 8'h03);
		w(4'h7, 8'h04);
		@(posedge CLK);
		#1 chk({6'h0, MULTI_SPEED_EN, ACCEL_EN}, 8'h01);
		w(4'h7, 8'h00);
		u_ppsr_link.sel(3'h1, 4'h0);
		rchk(4'h8, 8'h01);
		u_ppsr_link.sel(3'h7, 4'h0);
		rchk(4'h6, 8'hE1);
		w(4'hB, 8'h5A);
		rchk(4'hB, 8'h5A);
		u_ppsr_link.sel(3'h3, 4'h0);
		rchk(4'h8, 8'h00);
		rchk(4'h3, 8'h00);
		$display("control and pages done");
	end
	endtask

	always @(posedge CLK)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_total = err_total + 1;
			stop_test;
		end
	end

	initial
	begin
		repeat (5) @(posedge CLK);
		RST <= 1'b0;
		t_status;
		t_event;
		t_flags;
		t_ctrl;
		stop_test;
	end
endmodule // phy_port_status_register_page_tb

bind ppsr_top ppsr_monitor u_ppsr_monitor (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .ARB_TIMEOUT(ARB_TIMEOUT), .LOOP_EVT(LOOP_EVT),
	.PWR_FAIL_EVT(PWR_FAIL_EVT), .LINK_POWER_STATUS(LINK_POWER_STATUS), .PORT_OFF(PORT_OFF),
	.ACCEL_EN(ACCEL_EN), .MULTI_SPEED_EN(MULTI_SPEED_EN), .LINK_ON_INDICATION(LINK_ON_INDICATION));

/* testbench/ppsr_link.sv */
/*
 Link-side register master model with write, read and select tasks.
 Assumes the slave never stalls and read data stand the cycle after RD.
*/
`timescale 1ns/1ps

module ppsr_link
(
	input  wire       CLK,
	output reg  [3:0] ADDR = 4'h0,
	output reg  [7:0] WDATA = 8'h00,
	output reg        WR = 1'b0,
	output reg        RD = 1'b0,
	output reg        REQ_PENDING = 1'b0,
	input  wire [7:0] RDATA
);
	task wr(input [3:0] a, input [7:0] d);
	begin
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		REQ_PENDING <= (a != 4'h7);
		@(posedge CLK);
		WR <= 1'b0;
		ADDR <= ~a;
		WDATA <= ~d;
	end
	endtask

	task rd(input [3:0] a, output [7:0] d);
	begin
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		ADDR <= ~a;
		#1 d = RDATA;
	end
	endtask

	// The vendor-dependent page is only ever opened with port code 1.
	task sel(input [2:0] pg, input [3:0] pt);
		wr(4'h6, {pg, 1'b0, (pg == 3'h7) ? 4'h1 : pt});
	endtask
endmodule // ppsr_link

/* testbench/ppsr_monitor.sv */
/*
 Checker for the port status register page top, bound to its ports.
 Assumes RST is synchronous and active high and strobes last one cycle.
*/
`timescale 1ns/1ps

module ppsr_monitor
(
	input wire       CLK,
	input wire       RST,
	input wire [3:0] ADDR,
	input wire [7:0] WDATA,
	input wire       WR,
	input wire       RD,
	input wire [7:0] RDATA,
	input wire       ARB_TIMEOUT,
	input wire       LOOP_EVT,
	input wire       PWR_FAIL_EVT,
	input wire       LINK_POWER_STATUS,
	input wire [2:0] PORT_OFF,
	input wire       ACCEL_EN,
	input wire       MULTI_SPEED_EN,
	input wire       LINK_ON_INDICATION
);
	reg [7:0] sel_reg;
	reg [2:0] base_reg;

	// Shadows of the selector and of the writable base control bits.
	always @(posedge CLK)
	begin
		if (RST)
		begin
			sel_reg  <= 8'h00;
			base_reg <= 3'h0;
		end
		else if (WR && ADDR == 4'h6)
			sel_reg <= WDATA & 8'hEF;
		else if (WR && ADDR == 4'h7)
			base_reg <= WDATA[4:2];
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	chk_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
		else $error("read data not zero outside a read answer");
	chk_sel_readback: assert property (RD && ADDR == 4'h6 |=> RDATA == sel_reg)
		else $error("selector reads back wrong");
	chk_base_readback: assert property (RD && ADDR == 4'h7 |=> RDATA[7:2] == {3'h0, base_reg})
		else $error("base control bits read back wrong");
	chk_accel_follow: assert property (WR && ADDR == 4'h7 |-> ##2 ACCEL_EN == $past(WDATA[2], 2))
		else $error("acceleration enable does not follow its bit");
	chk_multi_follow: assert property (WR && ADDR == 4'h7 |-> ##2 MULTI_SPEED_EN == $past(WDATA[3], 2))
		else $error("multi-speed enable does not follow its bit");
	chk_reset_outs: assert property ($fell(RST) |-> PORT_OFF == 3'h0 && !ACCEL_EN && !MULTI_SPEED_EN)
		else $error("outputs not at reset values after reset");
	chk_lon_quiet: assert property (!$past(LINK_POWER_STATUS) && !base_reg[2] |-> !LINK_ON_INDICATION)
		else $error("link-on raised while gated off");
	chk_lon_raise: assert property (LINK_POWER_STATUS && (LOOP_EVT || PWR_FAIL_EVT) |=> LINK_ON_INDICATION)
		else $error("link-on not raised for loop or power fail");
	chk_timeout_lon: assert property (ARB_TIMEOUT && LINK_POWER_STATUS |-> ##[1:3] LINK_ON_INDICATION)
		else $error("time-out flag did not raise link-on");
endmodule // ppsr_monitor
